/* signed_and_exclusive_load_unit.sv */
// apb-controlled decode and execute unit for signed unscaled and exclusive loads
// Operation
// - halfword signed load with load-kind 11 gives a 32-bit sign-extended result
// - halfword signed load with load-kind 10 gives a 64-bit sign-extended result
// - nine-bit offset is sign-extended to 64 bits and added to the base
// - load-kind high bit zero: store or zero load, 32-bit, unsigned
// - load-kind high bit one: signed load, 32-bit if low bit set else 64
// - tag checking off when base index is 31
// - base index 31 uses stack pointer and checks its alignment
// - halfword store writes low 16 bits of transfer register, 2 bytes
// - halfword load reads 2 bytes, extends to register size by signedness
// - unscaled accesses are privileged unless at user level
// - signed word load reads 4 bytes
// - signed word load sign-extends and writes all 64 bits
// - pair element size is 32 shifted by pair width bit, total doubled
// - pair with equal destinations: unknown, undefined or no-operation
// - exclusive loads arm the monitor over the accessed byte range
// - exclusive loads record the address for later store-exclusive checks
// - 32-bit pair does one atomic access then splits between destinations
// - big-endian puts upper half first, little-endian lower half first
// - 64-bit pair faults unless aligned to the 16-byte total
// - 64-bit pair reads 8 bytes at base then at base plus 8
// - single exclusive reads 8 shifted by size bits, zero-extended
// - single exclusive destination is 32-bit for size 10, 64-bit for 11
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps

module signed_and_exclusive_load_unit #(
  parameter int OFFSET_W = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic mem_req_o,
  output logic mem_write_o,
  output logic [63:0] mem_addr_o,
  output logic [4:0] mem_bytes_o,
  output logic [63:0] mem_wdata_o,
  output logic mem_priv_o,
  output logic mem_tagchk_o,
  output logic mem_excl_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_rdata_i,
  output logic excl_set_o,
  output logic [63:0] excl_addr_o,
  output logic [4:0] excl_bytes_o,
  output logic busy_o
);
  import load_unit_pkg::*;

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    state_e st;
    kind_e kind;
    logic [31:0] instr;
    logic [63:0] base;
    logic [63:0] sp;
    logic [63:0] xfer;
    logic be;
    logic spchk;
    logic [1:0] el;
    logic done;
    logic busy;
    logic undef;
    logic afault;
    logic spfault;
    logic wr0;
    logic wr1;
    logic r64;
    logic sgn;
    logic [63:0] res0;
    logic [63:0] res1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mem_req;
    logic mem_write;
    logic [63:0] mem_addr;
    logic [4:0] mem_bytes;
    logic [63:0] mem_wdata;
    logic mem_priv;
    logic mem_tagchk;
    logic mem_excl;
    logic excl_set;
    logic [63:0] excl_addr;
    logic [4:0] excl_bytes;
  } unit_s;

  unit_s s_r;
  unit_s s_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge, shared by every writable word except the control register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // loaded data to register image, sign or zero extended
  function automatic logic [63:0] extend(input logic [63:0] d, input logic [4:0] bytes,
                                         input logic sgn, input logic r64);
    logic [63:0] v;
    v = d;
    case (bytes)
      5'h01: v = {{56{sgn & d[7]}}, d[7:0]};
      BYTES_HALF: v = {{48{sgn & d[15]}}, d[15:0]};
      BYTES_WORD: v = {{32{sgn & d[31]}}, d[31:0]};
      default: v = d;
    endcase
    if (!r64) begin
      v = {32'h0000_0000, v[31:0]};
    end
    return v;
  endfunction

  function automatic kind_e classify(input logic [31:0] w);
    kind_e k;
    k = K_BAD;
    if (w[31:30] == 2'h1 && w[29:24] == 6'h38 && w[21] == 1'b0 && w[11:10] == 2'h0) begin
      k = K_HALF;
    end else if (w[31:22] == 10'h2E2 && w[21] == 1'b0 && w[11:10] == 2'h0) begin
      k = K_WORD;
    end else if (w[31] && w[29:21] == 9'h043 && w[15] == 1'b0) begin
      k = K_PAIR;
    end else if (w[31] && w[29:21] == 9'h042 && w[15] == 1'b0) begin
      k = K_SINGLE;
    end
    return k;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFS_ADDR_HI;
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // decode fields
  logic [4:0] dest_reg_index;
  logic [4:0] base_reg_index;
  logic [4:0] second_dest_index;
  logic [OFFSET_W-1:0] byte_offset_field;
  logic pair_width_bit;
  assign dest_reg_index = s_r.instr[4:0];
  assign base_reg_index = s_r.instr[9:5];
  assign second_dest_index = s_r.instr[14:10];
  assign byte_offset_field = s_r.instr[20:12];
  assign pair_width_bit = s_r.instr[30];

  // one combinational pass over apb, decode and memory sequencing
  always_comb begin
    logic acc;
    logic wr_ok;
    logic idle;
    logic [31:0] rd;
    logic [63:0] off;
    logic [63:0] basev;
    logic [63:0] ea;
    logic [4:0] bytes;
    logic [1:0] opc;
    logic sp_base;
    logic excl;
    logic fault;
    acc = psel_i & penable_i;
    idle = s_r.st == ST_IDLE;
    wr_ok = acc & s_r.pready & pwrite_i & ~s_r.pslverr;
    rd = 32'h0000_0000;
    off = 64'h0;
    basev = 64'h0;
    ea = 64'h0;
    bytes = BYTES_DWORD;
    opc = s_r.instr[23:22];
    sp_base = base_reg_index == SP_INDEX;
    excl = 1'b0;
    fault = 1'b0;
    s_nxt = s_r;
    s_nxt.excl_set = 1'b0;

    // read mux, answered one cycle into the access phase
    case (paddr_i)
      OFS_INSTR: rd = s_r.instr;
      OFS_CTRL: rd = {26'h0, s_r.el, 1'b0, s_r.spchk, s_r.be, 1'b0};
      OFS_BASE_LO: rd = s_r.base[31:0];
      OFS_BASE_HI: rd = s_r.base[63:32];
      OFS_SP_LO: rd = s_r.sp[31:0];
      OFS_SP_HI: rd = s_r.sp[63:32];
      OFS_XFER_LO: rd = s_r.xfer[31:0];
      OFS_XFER_HI: rd = s_r.xfer[63:32];
      OFS_STATUS: rd = {11'h0, second_dest_index, 3'h0, dest_reg_index, s_r.r64, s_r.wr1, s_r.wr0,
                        s_r.spfault, s_r.afault, s_r.undef, s_r.done, ~idle};
      OFS_RES0_LO: rd = s_r.res0[31:0];
      OFS_RES0_HI: rd = s_r.res0[63:32];
      OFS_RES1_LO: rd = s_r.res1[31:0];
      OFS_RES1_HI: rd = s_r.res1[63:32];
      OFS_ADDR_LO: rd = s_r.mem_addr[31:0];
      OFS_ADDR_HI: rd = s_r.mem_addr[63:32];
      default: rd = 32'h0000_0000;
    endcase
    if (acc & ~s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = pwrite_i ? 32'h0000_0000 : rd;
      s_nxt.pslverr = ~mapped(paddr_i);
    end else begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end

    // register writes; operands are frozen while an instruction runs
    if (wr_ok) begin
      case (paddr_i)
        OFS_INSTR: if (idle) s_nxt.instr = merge(s_r.instr, pwdata_i, pstrb_i);
        OFS_BASE_LO: if (idle) s_nxt.base[31:0] = merge(s_r.base[31:0], pwdata_i, pstrb_i);
        OFS_BASE_HI: if (idle) s_nxt.base[63:32] = merge(s_r.base[63:32], pwdata_i, pstrb_i);
        OFS_SP_LO: if (idle) s_nxt.sp[31:0] = merge(s_r.sp[31:0], pwdata_i, pstrb_i);
        OFS_SP_HI: if (idle) s_nxt.sp[63:32] = merge(s_r.sp[63:32], pwdata_i, pstrb_i);
        OFS_XFER_LO: if (idle) s_nxt.xfer[31:0] = merge(s_r.xfer[31:0], pwdata_i, pstrb_i);
        OFS_XFER_HI: if (idle) s_nxt.xfer[63:32] = merge(s_r.xfer[63:32], pwdata_i, pstrb_i);
        OFS_CTRL: begin
          if (pstrb_i[0]) begin
            s_nxt.be = pwdata_i[CTRL_BE_BIT];
            s_nxt.spchk = pwdata_i[CTRL_SPCHK_BIT];
            s_nxt.el = pwdata_i[CTRL_EL_LSB +: 2];
            // a start while busy is dropped
            if (pwdata_i[CTRL_START_BIT] && idle) begin
              s_nxt.st = ST_DEC;
              s_nxt.kind = classify(s_r.instr);
              s_nxt.done = 1'b0;
              s_nxt.undef = 1'b0;
              s_nxt.afault = 1'b0;
              s_nxt.spfault = 1'b0;
              s_nxt.wr0 = 1'b0;
              s_nxt.wr1 = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    off = {{(64-OFFSET_W){byte_offset_field[OFFSET_W-1]}}, byte_offset_field};
    basev = sp_base ? s_r.sp : s_r.base;
    ea = (s_r.kind == K_HALF || s_r.kind == K_WORD) ? basev + off : basev;

    case (s_r.st)
      ST_IDLE: ;
      ST_DEC: begin
        s_nxt.mem_write = 1'b0;
        s_nxt.mem_wdata = 64'h0;
        s_nxt.mem_priv = s_r.el != USER_LEVEL;
        s_nxt.mem_tagchk = ~sp_base;
        case (s_r.kind)
          K_HALF: begin
            s_nxt.sgn = opc[1];
            s_nxt.r64 = opc[1] & ~opc[0];
            bytes = BYTES_HALF;
            if (opc == 2'h0) begin
              s_nxt.mem_write = 1'b1;
              s_nxt.mem_wdata = {48'h0, s_r.xfer[15:0]};
            end
          end
          K_WORD: begin
            bytes = BYTES_WORD;
            s_nxt.sgn = 1'b1;
            s_nxt.r64 = 1'b1;
          end
          K_PAIR: begin
            bytes = BYTES_DWORD;
            s_nxt.sgn = 1'b0;
            s_nxt.r64 = pair_width_bit;
            excl = 1'b1;
            s_nxt.mem_priv = 1'b0;
          end
          K_SINGLE: begin
            bytes = s_r.instr[30] ? BYTES_DWORD : BYTES_WORD;
            s_nxt.sgn = 1'b0;
            s_nxt.r64 = s_r.instr[30];
            excl = 1'b1;
            s_nxt.mem_priv = 1'b0;
          end
          default: ;
        endcase
        if (s_r.kind == K_BAD) begin
          s_nxt.undef = 1'b1;
          fault = 1'b1;
        end else if (s_r.kind == K_PAIR && dest_reg_index == second_dest_index) begin
          s_nxt.undef = 1'b1;
          fault = 1'b1;
        end else if (sp_base && s_r.spchk && s_r.sp[3:0] != 4'h0) begin
          s_nxt.spfault = 1'b1;
          fault = 1'b1;
        end else if (s_r.kind == K_PAIR && pair_width_bit && ea[3:0] != 4'h0) begin
          s_nxt.afault = 1'b1;
          fault = 1'b1;
        end
        if (fault) begin
          s_nxt.st = ST_IDLE;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.st = ST_MEM1;
          s_nxt.mem_req = 1'b1;
          s_nxt.mem_addr = ea;
          s_nxt.mem_bytes = bytes;
          s_nxt.mem_excl = excl;
          // arm the monitor over the range
          s_nxt.excl_set = excl;
          s_nxt.excl_addr = ea;
          s_nxt.excl_bytes = (s_r.kind == K_PAIR && pair_width_bit) ? BYTES_QUAD : bytes;
        end
      end
      ST_MEM1: begin
        if (mem_ack_i) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.st = ST_IDLE;
          s_nxt.done = 1'b1;
          s_nxt.wr0 = ~s_r.mem_write;
          if (s_r.kind == K_PAIR && !pair_width_bit) begin
            s_nxt.res0 = {32'h0, s_r.be ? mem_rdata_i[63:32] : mem_rdata_i[31:0]};
            s_nxt.res1 = {32'h0, s_r.be ? mem_rdata_i[31:0] : mem_rdata_i[63:32]};
            s_nxt.wr1 = 1'b1;
          end else if (s_r.kind == K_PAIR) begin
            // second read at base plus 8
            s_nxt.res0 = mem_rdata_i;
            s_nxt.wr0 = 1'b0;
            s_nxt.done = 1'b0;
            s_nxt.st = ST_MEM2;
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_excl = 1'b1;
            s_nxt.mem_addr = s_r.mem_addr + PAIR_SECOND_OFS;
          end else if (!s_r.mem_write) begin
            s_nxt.res0 = extend(mem_rdata_i, s_r.mem_bytes, s_r.sgn, s_r.r64);
          end
        end
      end
      ST_MEM2: begin
        if (mem_ack_i) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.res1 = mem_rdata_i;
          s_nxt.wr0 = 1'b1;
          s_nxt.wr1 = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // busy is registered from the next state so the pin comes straight from a flop
    s_nxt.busy = s_nxt.st != ST_IDLE;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // ce low freezes everything but reset, including an apb access in flight
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.be <= CTRL_BE_RST;
      s_r.spchk <= CTRL_SPCHK_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the record
  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign mem_req_o = s_r.mem_req;
  assign mem_write_o = s_r.mem_write;
  assign mem_addr_o = s_r.mem_addr;
  assign mem_bytes_o = s_r.mem_bytes;
  assign mem_wdata_o = s_r.mem_wdata;
  assign mem_priv_o = s_r.mem_priv;
  assign mem_tagchk_o = s_r.mem_tagchk;
  assign mem_excl_o = s_r.mem_excl;
  assign excl_set_o = s_r.excl_set;
  assign excl_addr_o = s_r.excl_addr;
  assign excl_bytes_o = s_r.excl_bytes;
  assign busy_o = s_r.busy;

endmodule

/* load_unit_pkg.sv */
// shared constants and enumerations for the signed and exclusive load unit
package load_unit_pkg;

  // ---------------------------------------------------------------
  // register byte offsets on the apb side
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_BASE_LO = 8'h08;
  localparam logic [7:0] OFS_BASE_HI = 8'h0C;
  localparam logic [7:0] OFS_SP_LO = 8'h10;
  localparam logic [7:0] OFS_SP_HI = 8'h14;
  localparam logic [7:0] OFS_XFER_LO = 8'h18;
  localparam logic [7:0] OFS_XFER_HI = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RES0_LO = 8'h24;
  localparam logic [7:0] OFS_RES0_HI = 8'h28;
  localparam logic [7:0] OFS_RES1_LO = 8'h2C;
  localparam logic [7:0] OFS_RES1_HI = 8'h30;
  localparam logic [7:0] OFS_ADDR_LO = 8'h34;
  localparam logic [7:0] OFS_ADDR_HI = 8'h38;

  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BE_BIT = 1;
  localparam int CTRL_SPCHK_BIT = 2;
  localparam int CTRL_EL_LSB = 4;
  localparam logic CTRL_BE_RST = 1'b0;
  localparam logic CTRL_SPCHK_RST = 1'b1;
  localparam logic [1:0] USER_LEVEL = 2'h0;
  localparam logic [4:0] SP_INDEX = 5'h1F;

  // ---------------------------------------------------------------
  // access sizes in bytes
  // ---------------------------------------------------------------
  localparam logic [4:0] BYTES_HALF = 5'h02;
  localparam logic [4:0] BYTES_WORD = 5'h04;
  localparam logic [4:0] BYTES_DWORD = 5'h08;
  localparam logic [4:0] BYTES_QUAD = 5'h10;
  localparam logic [63:0] PAIR_SECOND_OFS = 64'h0000_0000_0000_0008;

  // ---------------------------------------------------------------
  // sequencer states and instruction kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEC = 2'b01,
    ST_MEM1 = 2'b10,
    ST_MEM2 = 2'b11
  } state_e;

  typedef enum logic [2:0] {
    K_BAD = 3'b000,
    K_HALF = 3'b001,
    K_WORD = 3'b010,
    K_PAIR = 3'b011,
    K_SINGLE = 3'b100
  } kind_e;

endpackage

/* load_unit_checker_assertions.sv */
// concurrent checks on the memory side of the load unit
`timescale 1ns/100ps
module load_unit_checker #(
  parameter int OFFSET_W = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic mem_req_o,
  input wire logic mem_write_o,
  input wire logic [63:0] mem_addr_o,
  input wire logic [4:0] mem_bytes_o,
  input wire logic [63:0] mem_wdata_o,
  input wire logic mem_excl_o,
  input wire logic mem_ack_i,
  input wire logic excl_set_o,
  input wire logic [63:0] excl_addr_o,
  input wire logic [4:0] excl_bytes_o
);
  // ------------------------------------------------------------
  // request and monitor relations
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // first half of a 64-bit pair, the one access that does not end the instruction
  wire pair_first = mem_excl_o && excl_bytes_o == 5'h10 && mem_addr_o == excl_addr_o;
  a_store_half: assert property (mem_req_o && mem_write_o |->
    mem_bytes_o == 5'h02 && mem_wdata_o[63:16] == 48'h0) else $error("store is not a padded halfword");
  a_req_hold: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_bytes_o)) else $error("request changed before ack");
  a_pair_next: assert property (mem_req_o && mem_ack_i && pair_first |=>
    mem_req_o && mem_addr_o == excl_addr_o + 64'h8) else $error("second pair read missing");
  a_single_end: assert property (mem_req_o && mem_ack_i && !pair_first |=> !mem_req_o)
    else $error("extra access after ack");
  a_excl_arm: assert property (excl_set_o |-> mem_req_o && mem_excl_o && excl_addr_o == mem_addr_o)
    else $error("monitor armed away from access");
  a_excl_once: assert property (excl_set_o |=> !excl_set_o)
    else $error("monitor armed twice");
  a_excl_size: assert property (excl_set_o |-> excl_bytes_o == mem_bytes_o ||
    excl_bytes_o == 5'h10 && mem_bytes_o == 5'h08) else $error("reserved range size wrong");
  a_pair_align: assert property (excl_set_o && excl_bytes_o == 5'h10 |-> excl_addr_o[3:0] == 4'h0)
    else $error("unaligned wide pair reached memory");
  a_excl_read: assert property (mem_req_o && mem_excl_o |-> !mem_write_o)
    else $error("exclusive access writes");
  c_wide_pair: cover property (excl_set_o && excl_bytes_o == 5'h10);
  c_store: cover property (mem_req_o && mem_write_o);
  c_bus_err: cover property (pready_o && pslverr_o);
endmodule

bind signed_and_exclusive_load_unit load_unit_checker #(.OFFSET_W(OFFSET_W)) chk (.clk_sys_i, .rst_i,
  .pready_o, .pslverr_o, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_bytes_o, .mem_wdata_o, .mem_excl_o,
  .mem_ack_i, .excl_set_o, .excl_addr_o, .excl_bytes_o);

/* load_unit_mem_model.sv */
// behavioural memory answering the load unit's requests
`timescale 1ns/100ps
module load_unit_mem_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [63:0] addr_i,
  input wire logic [63:0] data_i,
  input wire logic [3:0] dly_i,
  output logic ack_o,
  output logic [63:0] rdata_o
);
  logic [3:0] cnt_r;
  // one ack per request after dly_i waits; read data is scrambled outside the ack
  always_ff @(posedge clk_sys_i) begin
    ack_o <= 1'b0;
    rdata_o <= rst_i ? 64'h0 : ~rdata_o;
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else if (req_i && !ack_o) begin
      if (cnt_r == dly_i) begin
        ack_o <= 1'b1;
        rdata_o <= data_i ^ addr_i;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

/* tb_signed_and_exclusive_load_unit.sv */
// self-checking bench for the signed and exclusive load unit
`timescale 1ns/100ps
module tb_signed_and_exclusive_load_unit;
  import load_unit_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o, q, st;
  logic pready_o, pslverr_o, mem_req_o, mem_write_o, mem_priv_o, mem_tagchk_o, mem_excl_o, mem_ack_i;
  logic excl_set_o, busy_o, perr, l_wr, l_priv, l_tag, l_excl;
  logic [63:0] mem_addr_o, mem_wdata_o, mem_rdata_i, excl_addr_o, l_addr, l_wdata, r0, r1, a, v;
  logic [4:0] mem_bytes_o, excl_bytes_o, l_bytes;
  logic [3:0] mem_dly = 4'h0;
  logic [63:0] mem_data = 64'h0123_4567_89AB_CDEF;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int nacc = 0;
  int n0;
  int narm = 0;
  int m0;

  signed_and_exclusive_load_unit #(.OFFSET_W(9)) DUT (.clk_sys_i, .rst_i, .ce_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_write_o,
    .mem_addr_o, .mem_bytes_o, .mem_wdata_o, .mem_priv_o, .mem_tagchk_o, .mem_excl_o, .mem_ack_i,
    .mem_rdata_i, .excl_set_o, .excl_addr_o, .excl_bytes_o, .busy_o);
  load_unit_mem_model mem (.clk_sys_i, .rst_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .data_i(mem_data),
    .dly_i(mem_dly), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // ------------------------------------------------------------
  // clock, access capture and hang guard
  // ------------------------------------------------------------
  always #10 clk_sys_i = ~clk_sys_i;
  // latch every completed access; the bench compares against these later
  always @(posedge clk_sys_i) begin
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      l_addr <= mem_addr_o;
      l_bytes <= mem_bytes_o;
      l_wr <= mem_write_o;
      l_wdata <= mem_wdata_o;
      l_priv <= mem_priv_o;
      l_tag <= mem_tagchk_o;
      l_excl <= mem_excl_o;
      nacc <= nacc + 1;
    end
    // count monitor arm pulses; a wide pair must arm only once
    if (excl_set_o === 1'b1) begin
      narm <= narm + 1;
    end
  end
  // a stuck handshake would otherwise spin forever
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; an idle cycle follows so the next setup never collides
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    q = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd64(input logic [7:0] ad, output logic [63:0] r);
    xfer(1'b0, ad, 32'h0);
    r[31:0] = q;
    xfer(1'b0, ad + 8'h4, 32'h0);
    r[63:32] = q;
  endtask
  // load base, instruction and control, start, poll for done, fetch both results
  task automatic run(input logic [31:0] ins, input logic [5:0] ctl, input logic [31:0] base);
    n0 = nacc;
    m0 = narm;
    xfer(1'b1, OFS_BASE_LO, base);
    xfer(1'b1, OFS_INSTR, ins);
    xfer(1'b1, OFS_CTRL, {26'h0, ctl | 6'h01});
    chk("busy", busy_o, 1'b1);
    q = 32'h0;
    for (int i = 0; i < 30 && q[1] !== 1'b1; i++) xfer(1'b0, OFS_STATUS, 32'h0);
    st = q;
    chk("done", st[1], 1'b1);
    chk("idle", busy_o, 1'b0);
    rd64(OFS_RES0_LO, r0);
    rd64(OFS_RES1_LO, r1);
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h4);
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", perr, 1'b1);
    chk("unmapped data", q, 32'h0);
    $display("test reset and map done");
    // halfword forms: signed 32, signed 64, zero load, store
    xfer(1'b1, OFS_XFER_LO, 32'h1234_ABCD);
    for (int k = 3; k >= 0; k--) begin
      a = (k == 3) ? 64'h0F00 : (k == 2) ? 64'h10FF : (k == 1) ? 64'h1000 : 64'h1001;
      v = mem_data ^ a;
      mem_dly <= 4'(k);
      run(32'h780000A3 | (k << 22) | ({23'h0, 9'(a - 64'h1000)} << 12), 6'({k[0], 4'h4}), 32'h1000);
      chk("half addr", l_addr, a);
      chk("half bytes", l_bytes, BYTES_HALF);
      chk("half priv", l_priv, k[0]);
      chk("half tag", l_tag, 1'b1);
      chk("half arm", narm, m0);
      chk("half excl", l_excl, 1'b0);
      chk("half write", l_wr, k == 0);
      chk("half wide", st[7], k == 2);
      if (k == 0) chk("store data", l_wdata, 64'hABCD);
      else chk("half res", r0, k == 2 ? {{48{v[15]}}, v[15:0]} :
        {32'h0, k[1] ? {16{v[15]}} : 16'h0, v[15:0]});
    end
    $display("test halfword done");
    // signed word off the stack pointer, then a misaligned stack pointer
    xfer(1'b1, OFS_SP_LO, 32'h2000);
    run(32'hB88103E7, 6'h04, 32'h0);
    v = mem_data ^ 64'h2010;
    chk("word addr", l_addr, 64'h2010);
    chk("word bytes", l_bytes, BYTES_WORD);
    chk("word tag", l_tag, 1'b0);
    chk("word res", r0, {{32{v[31]}}, v[31:0]});
    xfer(1'b1, OFS_SP_LO, 32'h2008);
    run(32'hB88103E7, 6'h04, 32'h0);
    chk("sp fault", st[4], 1'b1);
    chk("sp no access", nacc, n0);
    // with the alignment check disabled the same misaligned base must reach memory
    run(32'hB88103E7, 6'h00, 32'h0);
    chk("sp unchecked", l_addr, 64'h2018);
    $display("test word done");
    // narrow pair in both byte orders
    v = mem_data ^ 64'h3000;
    for (int b = 0; b < 2; b++) begin
      run(32'h887F1041, 6'(4 + 2 * b), 32'h3000);
      chk("pair range", excl_bytes_o, BYTES_DWORD);
      chk("pair resv", excl_addr_o, 64'h3000);
      chk("pair once", nacc, n0 + 1);
      chk("pair arm", narm, m0 + 1);
      chk("pair excl", l_excl, 1'b1);
      chk("pair res0", r0, {32'h0, b ? v[63:32] : v[31:0]});
      chk("pair res1", r1, {32'h0, b ? v[31:0] : v[63:32]});
    end
    // wide pair, then misaligned, then equal destinations
    run(32'hC87F1041, 6'h04, 32'h4000);
    chk("wide range", excl_bytes_o, BYTES_QUAD);
    chk("wide arm", narm, m0 + 1);
    chk("wide second", l_addr, 64'h4008);
    chk("wide res0", r0, mem_data ^ 64'h4000);
    chk("wide res1", r1, mem_data ^ 64'h4008);
    run(32'hC87F1041, 6'h04, 32'h4008);
    chk("align fault", st[3], 1'b1);
    chk("align no access", nacc, n0);
    run(32'h887F0441, 6'h04, 32'h3000);
    chk("overlap undef", st[2], 1'b1);
    $display("test pair done");
    // single exclusive, word and doubleword
    v = mem_data ^ 64'h5000;
    for (int s = 0; s < 2; s++) begin
      run(32'h885F7C41 | (s << 30), 6'h04, 32'h5000);
      chk("single bytes", l_bytes, s ? BYTES_DWORD : BYTES_WORD);
      chk("single wide", st[7], s[0]);
      chk("single excl", l_excl, 1'b1);
      chk("single res", r0, s ? v : {32'h0, v[31:0]});
    end
    run(32'h0, 6'h04, 32'h5000);
    chk("bad undef", st[2], 1'b1);
    $display("test single done");
    test_done();
  end
endmodule
